// ===== slps_map.vh
// Constants for the status lamp and network port select block.
// Assumes a 40 MHz system clock; all times are printed in ms.
`ifndef SLPS_MAP_VH
`define SLPS_MAP_VH

// Clock rate and times in their own unit
`define SLPS_CLK_HZ      40000000
`define SLPS_HALF_MS     500
`define SLPS_LINK_MS     50
`define SLPS_RESP_MS     1000
`define SLPS_FLICK_MS    30

// Register byte offsets (one 32-bit word each)
`define SLPS_REG_CTRL    4'h0
`define SLPS_REG_STAT    4'h4

// Control register fields and reset value
`define SLPS_CTRL_CFGOK  0
`define SLPS_CTRL_FAULT  1
`define SLPS_CTRL_RST    2'h0

// Status register fields
`define SLPS_ST_TPSEL    0
`define SLPS_ST_LINK     1
`define SLPS_ST_CFGMISS  2
`define SLPS_ST_HEALTH   3
`define SLPS_ST_LATE0    4
`define SLPS_ST_LATE1    5
`define SLPS_ST_IDLO     8
`define SLPS_ST_IDHI     11

// Serial port identity: input/output slot (value is arbitrary)
`define SLPS_IDENT_IO    4'h1

`endif

// ===== slps_sync.v
// Three-stage input synchroniser with agreement filter.
// Assumes inputs are asynchronous to sys_clk.
`timescale 1ns/100ps
`default_nettype none
module slps_sync #(
   parameter WIDTH = 1                     // Number of bits
) (
   input  wire             sys_clk,        // System clock
   input  wire             arst_n,         // Async reset, active low
   input  wire [WIDTH-1:0] asyncIn,        // Raw pin levels
   output reg  [WIDTH-1:0] syncOut_r       // Filtered levels
);

   reg [WIDTH-1:0] stage1_r;               // Metastable stage
   reg [WIDTH-1:0] stage2_r;               // Second stage
   reg [WIDTH-1:0] stage3_r;               // Third stage

   ////////////////////////////////////////////////////////////////////////
   // Chain; output follows only when stages two and three agree
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         stage1_r  <= {WIDTH{1'b0}};
         stage2_r  <= {WIDTH{1'b0}};
         stage3_r  <= {WIDTH{1'b0}};
         syncOut_r <= {WIDTH{1'b0}};
      end else begin
         stage1_r <= asyncIn;
         stage2_r <= stage1_r;
         stage3_r <= stage2_r;
         syncOut_r <= (stage2_r & stage3_r) |
                      (syncOut_r & (stage2_r | stage3_r));
      end
   end
endmodule
`default_nettype wire

// ===== slps_stretch.v
// Lamp pulse stretcher: a trigger lights the lamp for LEN cycles.
// Assumes a same-clock trigger; retrigger only after LEN dark cycles,
// so steady activity shows as a flicker rather than a solid lamp.
`timescale 1ns/100ps
`default_nettype none
module slps_stretch #(
   parameter        CW  = 21,              // Counter width
   parameter [CW-1:0] LEN = 21'd1200000    // On time in cycles
) (
   input  wire sys_clk,                    // System clock
   input  wire arst_n,                     // Async reset, active low
   input  wire trig,                       // Activity trigger
   output reg  lamp_r                      // Lamp drive
);

   reg [CW-1:0] cnt_r;                     // Remaining on+off time

   ////////////////////////////////////////////////////////////////////////
   // On for LEN cycles, then dark for LEN cycles before retrigger
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_r  <= {CW{1'b0}};
         lamp_r <= 1'b0;
      end else if (cnt_r == {CW{1'b0}}) begin
         if (trig) begin
            cnt_r  <= LEN;
            lamp_r <= 1'b1;
         end
      end else begin
         cnt_r <= cnt_r - {{(CW-1){1'b0}}, 1'b1};
         if (cnt_r == {{(CW-1){1'b0}}, 1'b1}) begin
            lamp_r <= 1'b0;                 // On phase ends; stays dark
            if (lamp_r)
               cnt_r <= LEN;                // Start dark gap
         end
      end
   end
endmodule
`default_nettype wire

// ===== slps_top.v
// Status lamps and network port select of the communication module.
// Assumes an Avalon-MM master on sys_clk, PHY signals asynchronous,
// serial and stack events as one-cycle pulses on sys_clk.
//
// Local design decisions: the register offsets and register access over Avalon-MM.
`include "slps_map.vh"
`timescale 1ns/100ps
`default_nettype none

//
// Behaviour
// - Health lamp lights about one second after reset
// - Hardware fault blinks health lamp, two-second period
// - Missing parameters blink health lamp once per second
// - Twisted-pair selected: AUI lamp off, link lamp on
// - Link pulse selects twisted pair, else AUI
// - AUI selected: AUI lamp on, link lamp dark
// - Receive lamp flickers on selected port activity
// - Configured healthy device answers each echo request
// - Serial receive lamp pulses on command arrival
// - Serial response and transmit lamp within second
// - Serial ports identify as input/output slots
// - Parameters-missing bit set whenever unconfigured, after reset
module slps_top #(
   parameter        CW       = 26,                  // Counter width
   parameter [25:0] HALF_CYC =                      // Half-second count
      `SLPS_CLK_HZ / 1000 * `SLPS_HALF_MS,
   parameter [25:0] LINK_CYC =                      // Link pulse timeout
      `SLPS_CLK_HZ / 1000 * `SLPS_LINK_MS,
   parameter [25:0] RESP_CYC =                      // Serial answer limit
      `SLPS_CLK_HZ / 1000 * `SLPS_RESP_MS,
   parameter [25:0] FLICK_CYC =                     // Lamp flicker time
      `SLPS_CLK_HZ / 1000 * `SLPS_FLICK_MS
) (
   input  wire        sys_clk,                      // 40 MHz clock
   input  wire        arst_n,                       // Async reset, low
   input  wire [3:0]  avs_address,                  // Byte address
   input  wire        avs_read,                     // Read request
   input  wire        avs_write,                    // Write request
   input  wire [3:0]  avs_byteenable,               // Byte lanes
   input  wire [31:0] avs_writedata,                // Write data
   output reg  [31:0] avs_readdata,                 // Read data
   output reg         avs_waitrequest,              // Stall
   input  wire        linkPulse,                    // TP link pulse pin
   input  wire        tpRxActive,                   // TP receive pin
   input  wire        auiRxActive,                  // AUI receive pin
   input  wire        echoRequest,                  // Echo request seen
   input  wire [1:0]  serialCmd,                    // Command arrived
   input  wire [1:0]  serialRespSent,               // Response sent
   output reg         healthLamp,                   // Health lamp
   output reg         link_pulse_lamp,              // Link lamp
   output reg         auiLamp,                      // AUI lamp
   output reg         tpSelect,                     // 1 = twisted pair
   output wire        receive_activity_lamp,        // Ethernet rx lamp
   output wire [1:0]  serialRxLamp,                 // Serial rx lamps
   output wire [1:0]  transmit_activity_lamp,       // Serial tx lamps
   output reg         echoReply,                    // Send echo reply
   output reg         cfgMissing,                   // Parameters unset
   output reg  [3:0]  slotIdent                     // Port identity
);

   ////////////////////////////////////////////////////////////////////////
   // Declarations
   reg  [1:0]    ctrl_r;                  // Config-ok and fault bits
   reg  [1:0]    late_r;                  // Sticky late-answer flags
   reg  [CW-1:0] halfCnt_r;               // Half-second prescaler
   reg  [1:0]    phase_r;                 // Half-second phase count
   reg           powerDone_r;             // Power-up delay over
   reg  [CW-1:0] linkCnt_r;               // Link pulse timeout
   reg           linkPrev_r;              // Link pulse previous level
   reg  [CW-1:0] respCnt_r [0:1];         // Answer timers
   reg  [1:0]    respBusy_r;              // Answer pending
   wire [2:0]    pinSync;                 // Synchronised pins
   wire          linkNow;                 // Link pulse level
   wire          halfTick;                // Half-second tick
   wire          linkSeen;                // Link pulse present
   wire          rxSel;                   // Selected port activity
   wire          reqWrite;                // Write accepted this edge
   wire          cfgOk;                   // Parameters set
   wire          hwFault;                 // Diagnostic fault
   wire [31:0]   statWord;                // Status register image

   assign cfgOk   = ctrl_r[`SLPS_CTRL_CFGOK];
   assign hwFault = ctrl_r[`SLPS_CTRL_FAULT];

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   slps_sync #(
      .WIDTH     (3)
   ) uPinSync (
      .sys_clk   (sys_clk),
      .arst_n    (arst_n),
      .asyncIn   ({auiRxActive, tpRxActive, linkPulse}),
      .syncOut_r (pinSync)
   );
   assign linkNow = pinSync[0];

   ////////////////////////////////////////////////////////////////////////
   // Free-running timebase shared by every blink pattern
   assign halfTick = (halfCnt_r == HALF_CYC - 26'd1);

   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         halfCnt_r   <= {CW{1'b0}};
         phase_r     <= 2'h0;
         powerDone_r <= 1'b0;
      end else begin
         if (halfTick) begin
            halfCnt_r <= {CW{1'b0}};
            phase_r   <= phase_r + 2'h1;
            // Two half-seconds after reset the lamp may light
            if (phase_r == 2'h1)
               powerDone_r <= 1'b1;
         end else begin
            halfCnt_r <= halfCnt_r + 26'd1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Health lamp pattern, fault first
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         healthLamp <= 1'b0;
      end else if (!powerDone_r) begin
         healthLamp <= 1'b0;
      end else if (hwFault) begin
         healthLamp <= phase_r[1];
      end else if (!cfgOk) begin
         healthLamp <= phase_r[0];
      end else begin
         healthLamp <= 1'b1;                 // Steady when healthy
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Link pulse presence: each rising edge restarts the timeout
   assign linkSeen = (linkCnt_r != {CW{1'b0}});

   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         linkCnt_r  <= {CW{1'b0}};
         linkPrev_r <= 1'b0;
      end else begin
         linkPrev_r <= linkNow;
         if (linkNow && !linkPrev_r)
            linkCnt_r <= LINK_CYC;
         else if (linkSeen)
            linkCnt_r <= linkCnt_r - 26'd1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Port select and port lamps
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         tpSelect        <= 1'b0;
         link_pulse_lamp <= 1'b0;
         auiLamp         <= 1'b1;
      end else begin
         tpSelect        <= linkSeen;
         link_pulse_lamp <= linkSeen;
         auiLamp         <= ~linkSeen;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Ethernet receive lamp follows only the selected port
   assign rxSel = tpSelect ? pinSync[1] : pinSync[2];

   slps_stretch #(
      .CW      (CW),
      .LEN     (FLICK_CYC)
   ) uRxLamp (
      .sys_clk (sys_clk),
      .arst_n  (arst_n),
      .trig    (rxSel),
      .lamp_r  (receive_activity_lamp)
   );

   ////////////////////////////////////////////////////////////////////////
   // Serial port lamps and answer timers, one set per port
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : gPort
         slps_stretch #(
            .CW      (CW),
            .LEN     (FLICK_CYC)
         ) uSerRx (
            .sys_clk (sys_clk),
            .arst_n  (arst_n),
            .trig    (serialCmd[gi]),
            .lamp_r  (serialRxLamp[gi])
         );
         slps_stretch #(
            .CW      (CW),
            .LEN     (FLICK_CYC)
         ) uSerTx (
            .sys_clk (sys_clk),
            .arst_n  (arst_n),
            .trig    (serialRespSent[gi]),
            .lamp_r  (transmit_activity_lamp[gi])
         );

         // Command starts the timer; response stops it
         always @(posedge sys_clk or negedge arst_n) begin
            if (!arst_n) begin
               respCnt_r[gi]  <= {CW{1'b0}};
               respBusy_r[gi] <= 1'b0;
            end else if (serialRespSent[gi]) begin
               respBusy_r[gi] <= 1'b0;
            end else if (serialCmd[gi]) begin
               respCnt_r[gi]  <= RESP_CYC;
               respBusy_r[gi] <= 1'b1;
            end else if (respBusy_r[gi]) begin
               respCnt_r[gi] <= respCnt_r[gi] - 26'd1;
               if (respCnt_r[gi] == 26'd1)
                  respBusy_r[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Echo reply and configuration status toward the controller
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         echoReply  <= 1'b0;
         cfgMissing <= 1'b1;
         slotIdent  <= 4'h0;
      end else begin
         echoReply  <= echoRequest & cfgOk & ~hwFault;
         cfgMissing <= ~cfgOk;
         slotIdent  <= `SLPS_IDENT_IO;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Avalon-MM slave: one wait cycle per access
   assign reqWrite = avs_write & ~avs_waitrequest;

   assign statWord = {20'h00000, slotIdent, 2'h0, late_r, healthLamp,
                      cfgMissing, linkSeen, tpSelect};

   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h00000000;
      end else if ((avs_read | avs_write) && avs_waitrequest) begin
         avs_waitrequest <= 1'b0;           // Answer next cycle
         if (avs_address == `SLPS_REG_CTRL)
            avs_readdata <= {30'h00000000, ctrl_r};
         else if (avs_address == `SLPS_REG_STAT)
            avs_readdata <= statWord;
         else
            avs_readdata <= 32'h00000000;   // Unmapped reads zero
      end else begin
         avs_waitrequest <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Control register; cleared by reset so parameters read as missing
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_r <= `SLPS_CTRL_RST;
      end else if (reqWrite && avs_byteenable[0] &&
                   avs_address == `SLPS_REG_CTRL) begin
         ctrl_r <= avs_writedata[1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Late-answer flags: timer expiry sets, write-one clears, set wins
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         late_r <= 2'h0;
      end else begin
         if (reqWrite && avs_byteenable[0] &&
             avs_address == `SLPS_REG_STAT)
            late_r <= (late_r & ~avs_writedata[5:4]) | lateSet(0);
         else
            late_r <= late_r | lateSet(0);
      end
   end

   // Expiry of each answer timer this cycle
   function [1:0] lateSet;
      input dummy;
      integer k;
      begin
         for (k = 0; k < 2; k = k + 1)
            lateSet[k] = respBusy_r[k] && !serialRespSent[k] &&
                         (respCnt_r[k] == 26'd1);
      end
   endfunction

endmodule
`default_nettype wire

// ===== slps_top_properties.sv
// Port checker for the status lamp and port select block.
// Assumes it is bound to slps_top with the counts handed on.
`timescale 1ns/100ps
`default_nettype none
module slps_checker #(
   parameter [25:0] HALF_CYC = 26'd20,           // Half-second count
   parameter [25:0] LINK_CYC = 26'd50            // Link timeout
) (
   input wire logic       sys_clk,               // Clock
   input wire logic       arst_n,                // Reset, low
   input wire logic       avs_read,              // Bus read
   input wire logic       avs_write,             // Bus write
   input wire logic       avs_waitrequest,       // Bus stall
   input wire logic       linkPulse,             // Link pin
   input wire logic       echoRequest,           // Echo seen
   input wire logic [1:0] serialCmd,             // Commands
   input wire logic [1:0] serialRespSent,        // Responses
   input wire logic       healthLamp,            // Health lamp
   input wire logic       link_pulse_lamp,       // Link lamp
   input wire logic       auiLamp,               // AUI lamp
   input wire logic       tpSelect,              // Port select
   input wire logic       receive_activity_lamp, // Rx lamp
   input wire logic [1:0] serialRxLamp,          // Serial rx
   input wire logic [1:0] transmit_activity_lamp, // Serial tx
   input wire logic       echoReply,             // Echo reply
   input wire logic       cfgMissing,            // Params unset
   input wire logic [3:0] slotIdent              // Identity
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   ////////////////////////////////////////////////////////////////
   logic [7:0] upCnt;                            // Cycles since reset
   logic [7:0] lowCnt;                           // Cycles since pulse
   // Saturating counters of time since reset and since a link pulse
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         upCnt  <= 8'h00;
         lowCnt <= 8'h00;
      end else begin
         if (upCnt != 8'hff) upCnt <= upCnt + 8'h01;
         if (linkPulse) lowCnt <= 8'h00;
         else if (lowCnt != 8'hff) lowCnt <= lowCnt + 8'h01;
      end
   end
   ////////////////////////////////////////////////////////////////
   lamp_pair_a: assert property (link_pulse_lamp != auiLamp)
      else $error("link and aui lamps agree");
   tp_lamp_a: assert property (tpSelect == link_pulse_lamp)
      else $error("port select and link lamp differ");
   link_drop_a: assert property (lowCnt > LINK_CYC + 8 |-> !tpSelect)
      else $error("twisted pair kept without link pulses");
   link_rise_a: assert property ($rose(tpSelect) |-> lowCnt < 8)
      else $error("twisted pair chosen without a link pulse");
   echo_cause_a: assert property (echoReply |->
      $past(echoRequest) && !$past(cfgMissing))
      else $error("echo reply without a configured request");
   cfg_hold_a: assert property ($changed(cfgMissing) |->
      $past(avs_write) || $past(avs_write, 2))
      else $error("parameters bit moved without a write");
   up_dark_a: assert property (upCnt < 2 * HALF_CYC - 4 |->
      !healthLamp)
      else $error("health lamp lit before power-up delay");
   ident_io_a: assert property ($past(arst_n) |-> slotIdent == 4'h1)
      else $error("serial identity is not an io slot");
   bus_answer_a: assert property ((avs_read || avs_write) &&
      avs_waitrequest |=> !avs_waitrequest)
      else $error("bus access not answered in one cycle");
   bus_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("bus answer longer than one cycle");
   rx_flick_a: assert property ($rose(receive_activity_lamp) |->
      receive_activity_lamp[*4] ##1 (!receive_activity_lamp)[*4])
      else $error("receive lamp does not flicker");
   ser_rx_a: assert property ($rose(serialRxLamp[0]) |->
      $past(serialCmd[0]) || $past(serialCmd[0], 2))
      else $error("serial rx lamp without a command");
   ser_tx_a: assert property ($rose(transmit_activity_lamp[1]) |->
      $past(serialRespSent[1]) || $past(serialRespSent[1], 2))
      else $error("serial tx lamp without a response");
endmodule
bind slps_top slps_checker #(.HALF_CYC(HALF_CYC), .LINK_CYC(LINK_CYC))
   slps_checker_i (.sys_clk, .arst_n, .avs_read, .avs_write,
   .avs_waitrequest, .linkPulse, .echoRequest, .serialCmd,
   .serialRespSent, .healthLamp, .link_pulse_lamp, .auiLamp, .tpSelect,
   .receive_activity_lamp, .serialRxLamp, .transmit_activity_lamp,
   .echoReply, .cfgMissing, .slotIdent);
`default_nettype wire

// ===== slps_hub.sv
// Model of the hub and AUI transceiver at the network pins.
// Assumes the bench clock as time base; pins change after its edge.
`timescale 1ns/100ps
`default_nettype none
module slps_hub (
   input  wire logic sys_clk,      // Time base
   input  wire logic linkOn,       // Hub cable attached
   input  wire logic trafficOn,    // Network busy
   output var  logic linkPulse,    // Link pulse pin
   output var  logic tpRxActive,   // Twisted pair activity
   output var  logic auiRxActive   // AUI activity
);
   logic [4:0] tick = 5'h00;       // Free-running time base
   initial begin
      linkPulse   = 1'b0;
      tpRxActive  = 1'b0;
      auiRxActive = 1'b0;
   end
   // Pulse every 32 cycles, inside the link timeout; activity toggles
   always @(posedge sys_clk) begin
      tick        <= tick + 5'h01;
      linkPulse   <= linkOn && tick < 5'h04;
      tpRxActive  <= trafficOn && linkOn && tick[1];
      auiRxActive <= trafficOn && !linkOn && tick[1];
   end
endmodule
`default_nettype wire

// ===== tb_slps_top.sv
// Self-checking bench for the status lamp and port select block.
// Assumes shortened counts; the hub model drives the network pins.
`timescale 1ns/100ps
`default_nettype none
module tb_slps_top;
   logic        sys_clk = 1'b0;          // 40 MHz clock
   logic        arst_n = 1'b0;           // Reset, active low
   logic [3:0]  avsAddr = 4'h0;          // Bus address
   logic        avsRead = 1'b0;          // Bus read
   logic        avsWrite = 1'b0;         // Bus write
   logic [3:0]  avsBe = 4'hf;            // Byte lanes
   logic [31:0] avsWdata = 32'h0;        // Write data
   logic        echoReq = 1'b0;          // Echo request pulse
   logic [1:0]  serCmd = 2'h0;           // Command pulses
   logic [1:0]  serResp = 2'h0;          // Response pulses
   logic        linkOn = 1'b0;           // Hub attached
   logic        trafficOn = 1'b0;        // Network busy
   wire  [31:0] avsRdata;                // Read data
   wire         avsWait, linkPulse, tpRx, auiRx, health, lpLamp;
   wire         auiLamp, tpSel, rxLamp, echoRep, cfgMiss;
   wire  [1:0]  serRx, serTx;            // Serial lamps
   wire  [3:0]  ident;                   // Port identity
   logic [31:0] q;                       // Last read data
   logic [1:0]  ctl [4] = '{2'h1, 2'h0, 2'h3, 2'h2}; // Echo cases
   int          n_errors = 0;            // Mismatches
   int          checked = 0;             // Comparisons
   int          cyc = 0;                 // Cycles since reset
   int          hi, tg;                  // Lamp on time, toggles
   ////////////////////////////////////////////////////////////////
   // Clock and cycle count
   always #12.5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) if (arst_n) cyc <= cyc + 1;
   slps_top #(.HALF_CYC(26'd20), .LINK_CYC(26'd50), .RESP_CYC(26'd100),
      .FLICK_CYC(26'd4)) slps_top_i (
      .sys_clk(sys_clk), .arst_n(arst_n), .avs_address(avsAddr),
      .avs_read(avsRead), .avs_write(avsWrite), .avs_byteenable(avsBe),
      .avs_writedata(avsWdata), .avs_readdata(avsRdata),
      .avs_waitrequest(avsWait), .linkPulse(linkPulse),
      .tpRxActive(tpRx), .auiRxActive(auiRx), .echoRequest(echoReq),
      .serialCmd(serCmd), .serialRespSent(serResp), .healthLamp(health),
      .link_pulse_lamp(lpLamp), .auiLamp(auiLamp), .tpSelect(tpSel),
      .receive_activity_lamp(rxLamp), .serialRxLamp(serRx),
      .transmit_activity_lamp(serTx), .echoReply(echoRep),
      .cfgMissing(cfgMiss), .slotIdent(ident));
   slps_hub slps_hub_i (.sys_clk(sys_clk), .linkOn(linkOn),
      .trafficOn(trafficOn), .linkPulse(linkPulse), .tpRxActive(tpRx),
      .auiRxActive(auiRx));
   ////////////////////////////////////////////////////////////////
   // Compare one value
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      checked++;
      if (g !== e) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One bus access, held until the stall drops
   task automatic bus(input logic wr, input logic [3:0] a,
                      input logic [31:0] d, input logic [3:0] be);
      int n;
      n = 0;
      @(posedge sys_clk);
      avsAddr <= a;
      avsWdata <= d;
      avsBe <= be;
      avsWrite <= wr;
      avsRead <= !wr;
      do begin
         @(posedge sys_clk);
         q = avsRdata;
         n++;
      end while (avsWait !== 1'b0 && n < 20);
      avsWrite <= 1'b0;
      avsRead <= 1'b0;
      if (n >= 20) chk("bus answer", 0, 1);
   endtask
   // One-cycle event pulse: 0 echo, 1 command, 2 response
   task automatic pulse(input int kind, input int p);
      @(posedge sys_clk);
      if (kind == 0) echoReq <= 1'b1;
      else if (kind == 1) serCmd[p] <= 1'b1;
      else serResp[p] <= 1'b1;
      @(posedge sys_clk);
      echoReq <= 1'b0;
      serCmd <= 2'h0;
      serResp <= 2'h0;
      @(negedge sys_clk);
   endtask
   // Lit samples and toggles of the health or receive lamp
   task automatic meas(input logic sel, input int n);
      logic v, prev;
      hi = 0;
      tg = 0;
      repeat (2) @(negedge sys_clk);
      prev = sel ? rxLamp : health;
      repeat (n) begin
         @(negedge sys_clk);
         v = sel ? rxLamp : health;
         hi += (v === 1'b1);
         tg += (v !== prev);
         prev = v;
      end
   endtask
   // Verdict and end of run
   task automatic summarize;
      $display("Checks %0d, mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // Watchdog: the tests need about 1300 cycles
   initial begin
      #250000;
      n_errors++;
      summarize();
   end
   ////////////////////////////////////////////////////////////////
   // Test sequence
   initial begin
      repeat (3) @(posedge sys_clk);
      chk("aui lamp in reset", 1, auiLamp);
      chk("params bit in reset", 1, cfgMiss);
      arst_n <= 1'b1;
      bus(0, 4'h4, 0, 4'hf);
      chk("status after reset", 32'h104, q);
      bus(0, 4'h8, 0, 4'hf);
      chk("unmapped read", 0, q);
      bus(1, 4'h0, 32'h1, 4'he);
      bus(0, 4'h0, 0, 4'hf);
      chk("ctrl lane off", 0, q);
      bus(1, 4'h0, 32'h1, 4'hf);
      bus(0, 4'h0, 0, 4'hf);
      chk("ctrl set", 1, q);
      chk("params bit clear", 0, cfgMiss);
      while (cyc < 46) @(negedge sys_clk);
      meas(0, 40);
      chk("health steady", 40, hi);
      $display("Test power_up done");
      bus(1, 4'h0, 32'h0, 4'hf);
      meas(0, 80);
      chk("params blink on", 40, hi);
      chk("params blink edges", 4, tg);
      bus(1, 4'h0, 32'h3, 4'hf);
      meas(0, 160);
      chk("fault blink on", 80, hi);
      chk("fault blink edges", 4, tg);
      bus(1, 4'h0, 32'h2, 4'hf);
      meas(0, 160);
      chk("fault priority", 4, tg);
      $display("Test health_patterns done");
      foreach (ctl[i]) begin
         bus(1, 4'h0, {30'h0, ctl[i]}, 4'hf);
         pulse(0, 0);
         chk("echo reply", ctl[i] == 2'h1, echoRep);
         @(negedge sys_clk);
         chk("echo single", 0, echoRep);
      end
      $display("Test echo done");
      linkOn <= 1'b1;
      trafficOn <= 1'b1;
      repeat (40) @(negedge sys_clk);
      chk("tp select", 1, tpSel);
      chk("link lamp on", 1, lpLamp);
      chk("aui lamp off", 0, auiLamp);
      meas(1, 40);
      chk("rx flicker tp", 1, hi > 0 && hi < 40);
      bus(0, 4'h4, 0, 4'hf);
      chk("status link", 3, q & 3);
      linkOn <= 1'b0;
      repeat (70) @(negedge sys_clk);
      chk("aui select", 0, tpSel);
      chk("aui lamp on", 1, auiLamp);
      chk("link lamp dark", 0, lpLamp);
      meas(1, 40);
      chk("rx flicker aui", 1, hi > 0 && hi < 40);
      trafficOn <= 1'b0;
      $display("Test port_select done");
      for (int p = 0; p < 2; p++) begin
         pulse(1, p);
         @(negedge sys_clk);
         chk("serial rx lamp", 1, serRx[p]);
         repeat (30) @(negedge sys_clk);
         pulse(2, p);
         @(negedge sys_clk);
         chk("serial tx lamp", 1, serTx[p]);
         repeat (120) @(negedge sys_clk);
         bus(0, 4'h4, 0, 4'hf);
         chk("no late flag", 0, q[5:4]);
         pulse(1, p);
         repeat (120) @(negedge sys_clk);
         bus(0, 4'h4, 0, 4'hf);
         chk("late flag", 1 << p, q[5:4]);
         bus(1, 4'h4, 32'h30, 4'hf);
         bus(0, 4'h4, 0, 4'hf);
         chk("late cleared", 0, q[5:4]);
      end
      $display("Test serial done");
      summarize();
   end
endmodule
`default_nettype wire
